// ### core/mads_params.svh
/*
  Constants of the 8-bit datapath core: register map, flag layout,
  command word fields and reset values.
  Assumes a 32-bit APB slave with an 8-bit byte address.
*/
// Summary of operation
// - zero flag set when result is zero
// - carry on sum carry-out or subtract borrow
// - half carry on low nibble carry-out or subtract borrow
// - bit operands only at addresses 0..7F
// - immediate load and stores keep flags
// - memory or IO load updates zero only
// - timer count copied to memory word
// - memory word loaded into timer count
// - indirect move through pointer, two cycles
// - exchange accumulator and memory byte
// - save pair at stack, pointer plus two
// - pointer minus two, then restore pair
// - add immediate or memory, four flags
// - add with carry, carry-only forms
// - negate destination then add other operand
// - subtract by adding two's complement
// - subtract with borrow, borrow-only forms
// - increment or decrement memory, four flags
// - clear memory byte, flags untouched
// - logical shifts insert zero, out to carry
// - rotates through carry, only carry changes
// - nibble swap of accumulator, no flags
// - overflow flag on signed range exceeded
`ifndef MADS_PARAMS_SVH
`define MADS_PARAMS_SVH

// register byte offsets
`define MADS_REG_CMD   8'h00
`define MADS_REG_ACC   8'h04
`define MADS_REG_FLAG  8'h08
`define MADS_REG_SP    8'h0C
`define MADS_REG_T16   8'h10
`define MADS_REG_CTRL  8'h14
`define MADS_REG_WADDR 8'h18
`define MADS_REG_WDATA 8'h1C
`define MADS_REG_STAT  8'h20

// flag register bit positions
`define MADS_F_Z  0
`define MADS_F_C  1
`define MADS_F_AC 2
`define MADS_F_OV 3

// command word fields
`define MADS_CMD_MEM   5
`define MADS_CMD_IMM   6
`define MADS_CMD_CONLY 7
`define MADS_CMD_AD_LO 8
`define MADS_CMD_IM_LO 16
`define MADS_CMD_BT_LO 24

// control and status bits
`define MADS_CTRL_TEN  0
`define MADS_CTRL_WIO  1
`define MADS_STAT_BSY  0
`define MADS_STAT_ERR  1

// limits, steps and reset values
`define MADS_BIT_MAX   8'h7F
`define MADS_SP_STEP   8'h02
`define MADS_RST_ACC   8'h00
`define MADS_RST_FLAG  4'h0
`define MADS_RST_SP    8'h00
`define MADS_RST_T16   16'h0000

`endif

// ### core/mads_pkg.sv
/*
  Types of the 8-bit datapath core: operation codes and states.
  Assumes mads_params.svh for the numeric constants.
*/
package mads_pkg;

  typedef enum logic [4:0] {
    MADS_OP_NOP  = 5'h00, MADS_OP_LDA  = 5'h01, MADS_OP_STM  = 5'h02,
    MADS_OP_LDIO = 5'h03, MADS_OP_STIO = 5'h04, MADS_OP_LDT  = 5'h05,
    MADS_OP_STT  = 5'h06, MADS_OP_IDXR = 5'h07, MADS_OP_IDXW = 5'h08,
    MADS_OP_XCH  = 5'h09, MADS_OP_PUSH = 5'h0A, MADS_OP_POP  = 5'h0B,
    MADS_OP_ADD  = 5'h0C, MADS_OP_ADDC = 5'h0D, MADS_OP_NADD = 5'h0E,
    MADS_OP_SUB  = 5'h0F, MADS_OP_SUBC = 5'h10, MADS_OP_INC  = 5'h11,
    MADS_OP_DEC  = 5'h12, MADS_OP_CLR  = 5'h13, MADS_OP_SHR  = 5'h14,
    MADS_OP_RRC  = 5'h15, MADS_OP_SHL  = 5'h16, MADS_OP_RLC  = 5'h17,
    MADS_OP_SWAP = 5'h18, MADS_OP_BCLR = 5'h19, MADS_OP_BSET = 5'h1A
  } mads_op_t;

  typedef enum logic [0:0] {
    MADS_ST_IDLE = 1'b0,
    MADS_ST_PTR  = 1'b1
  } mads_state_t;

endpackage

// ### core/mads_core.sv
/*
  8-bit datapath core: moves, timer word transfers, indirect access,
  exchange, stack save/restore, add/subtract family, shifts, rotates
  and nibble swap, with data memory, IO bytes and a 16-bit timer.
  Assumes an APB master on pclk; commands are issued by writing the
  command register.
*/
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "mads_params.svh"
module mads_core #(
  parameter int MEM_DEPTH = 256,
  parameter int IO_DEPTH  = 64
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  localparam int MAW = $clog2(MEM_DEPTH);
  localparam int IAW = $clog2(IO_DEPTH);

  // --------------------------------------------------------------
  // alu
  // --------------------------------------------------------------
  // returns {ov, ac, c, result}; sub turns carries into borrows
  function automatic logic [10:0] alu(input logic [7:0] x,
                                      input logic [7:0] y,
                                      input logic       ci,
                                      input logic       sub);
    logic [7:0] yy;
    logic       cc;
    logic [4:0] lo;
    logic [8:0] fu;
    yy  = sub ? ~y : y;
    cc  = ci ^ sub;
    lo  = {1'b0, x[3:0]} + {1'b0, yy[3:0]} + {4'h0, cc};
    fu  = {1'b0, x} + {1'b0, yy} + {8'h00, cc};
    alu = {(x[7] == yy[7]) && (fu[7] != x[7]),
           lo[4] ^ sub, fu[8] ^ sub, fu[7:0]};
  endfunction

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  logic [7:0]           acc_q, acc_d;
  logic [3:0]           flag_q, flag_d;
  logic [7:0]           sp_q, sp_d;
  logic [15:0]          t16_q;
  logic                 t16_en_q;
  logic                 win_io_q;
  logic [7:0]           waddr_q;
  logic                 err_q;
  logic [7:0]           ptr_q;
  mads_pkg::mads_op_t   ind_op_q;
  mads_pkg::mads_state_t state_q;
  logic [7:0]           mem_q [MEM_DEPTH];
  logic [7:0]           io_q  [IO_DEPTH];

  // --------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------
  logic                 acc_ph, wr, go;
  logic                 hit_any;
  mads_pkg::mads_op_t   op_w;
  logic                 to_mem, use_imm, conly;
  logic [7:0]           ad, imm, ad1, mem_rd, io_rd;
  logic [2:0]           bsel;

  assign pready  = (state_q == mads_pkg::MADS_ST_IDLE);
  assign acc_ph  = psel & penable & pready;
  assign wr      = acc_ph & pwrite;
  assign go      = wr & (paddr == `MADS_REG_CMD);
  assign op_w    = mads_pkg::mads_op_t'(pwdata[4:0]);
  assign to_mem  = pwdata[`MADS_CMD_MEM];
  assign use_imm = pwdata[`MADS_CMD_IMM];
  assign conly   = pwdata[`MADS_CMD_CONLY];
  assign ad      = pwdata[`MADS_CMD_AD_LO +: 8];
  assign imm     = pwdata[`MADS_CMD_IM_LO +: 8];
  assign bsel    = pwdata[`MADS_CMD_BT_LO +: 3];
  assign ad1     = ad + 8'h01;
  assign mem_rd  = mem_q[ad[MAW-1:0]];
  assign io_rd   = io_q[ad[IAW-1:0]];

  always_comb begin
    case (paddr)
      `MADS_REG_CMD, `MADS_REG_ACC, `MADS_REG_FLAG, `MADS_REG_SP,
      `MADS_REG_T16, `MADS_REG_CTRL, `MADS_REG_WADDR,
      `MADS_REG_WDATA, `MADS_REG_STAT: hit_any = 1'b1;
      default:                         hit_any = 1'b0;
    endcase
  end

  assign pslverr = acc_ph & ~hit_any;

  // --------------------------------------------------------------
  // alu operand select
  // --------------------------------------------------------------
  logic [7:0]  ax, ay;
  logic        aci, asub;
  logic [10:0] ar;

  always_comb begin
    ax   = acc_q;
    ay   = use_imm ? imm : mem_rd;
    aci  = 1'b0;
    asub = 1'b0;
    case (op_w)
      mads_pkg::MADS_OP_ADDC: begin
        ax  = (conly && to_mem) ? mem_rd : acc_q;
        ay  = conly ? 8'h00 : mem_rd;
        aci = flag_q[`MADS_F_C];
      end
      mads_pkg::MADS_OP_NADD: begin
        asub = 1'b1;
        ax   = to_mem ? acc_q : mem_rd;
        ay   = to_mem ? mem_rd : acc_q;
      end
      mads_pkg::MADS_OP_SUB: begin
        asub = 1'b1;
        ax   = to_mem ? mem_rd : acc_q;
        ay   = to_mem ? acc_q : (use_imm ? imm : mem_rd);
      end
      mads_pkg::MADS_OP_SUBC: begin
        asub = 1'b1;
        aci  = flag_q[`MADS_F_C];
        ax   = to_mem ? mem_rd : acc_q;
        ay   = conly ? 8'h00 : (to_mem ? acc_q : mem_rd);
      end
      mads_pkg::MADS_OP_INC, mads_pkg::MADS_OP_DEC: begin
        asub = (op_w == mads_pkg::MADS_OP_DEC);
        ax   = mem_rd;
        ay   = 8'h01;
      end
      default: begin
      end
    endcase
    ar = alu(ax, ay, aci, asub);
  end

  // --------------------------------------------------------------
  // execute
  // --------------------------------------------------------------
  logic        mwe0, mwe1, iowe, err_set, t16_ld, arith, shift;
  logic [7:0]  mwa0, mwd0, mwa1, mwd1, ioa, iod, shsrc, shres;
  logic        shco;
  logic [15:0] t16_v;

  always_comb begin
    acc_d   = acc_q;
    flag_d  = flag_q;
    sp_d    = sp_q;
    mwe0    = 1'b0;
    mwa0    = ad;
    mwd0    = acc_q;
    mwe1    = 1'b0;
    mwa1    = ad1;
    mwd1    = 8'h00;
    iowe    = 1'b0;
    ioa     = ad;
    iod     = acc_q;
    err_set = 1'b0;
    t16_ld  = 1'b0;
    t16_v   = {mem_q[ad1[MAW-1:0]], mem_rd};
    arith   = 1'b0;
    shift   = 1'b0;
    shsrc   = to_mem ? mem_rd : acc_q;
    shres   = shsrc;
    shco    = flag_q[`MADS_F_C];
    if (go) begin
      case (op_w)
        mads_pkg::MADS_OP_LDA: begin
          acc_d = use_imm ? imm : mem_rd;
          if (!use_imm)
            flag_d[`MADS_F_Z] = (mem_rd == 8'h00);
        end
        mads_pkg::MADS_OP_STM:  mwe0 = 1'b1;
        mads_pkg::MADS_OP_LDIO: begin
          acc_d             = io_rd;
          flag_d[`MADS_F_Z] = (io_rd == 8'h00);
        end
        mads_pkg::MADS_OP_STIO: iowe = 1'b1;
        mads_pkg::MADS_OP_LDT: begin
          mwe0 = 1'b1;
          mwd0 = t16_q[7:0];
          mwe1 = 1'b1;
          mwd1 = t16_q[15:8];
        end
        mads_pkg::MADS_OP_STT:  t16_ld = 1'b1;
        mads_pkg::MADS_OP_XCH: begin
          acc_d = mem_rd;
          mwe0  = 1'b1;
        end
        mads_pkg::MADS_OP_PUSH: begin
          mwe0 = 1'b1;
          mwa0 = sp_q;
          mwe1 = 1'b1;
          mwa1 = sp_q + 8'h01;
          mwd1 = {4'h0, flag_q};
          sp_d = sp_q + `MADS_SP_STEP;
        end
        mads_pkg::MADS_OP_POP: begin
          sp_d   = sp_q - `MADS_SP_STEP;
          acc_d  = mem_q[sp_d[MAW-1:0]];
          flag_d = mem_q[(sp_d[MAW-1:0]) + MAW'(1)][3:0];
        end
        mads_pkg::MADS_OP_ADD, mads_pkg::MADS_OP_ADDC,
        mads_pkg::MADS_OP_NADD, mads_pkg::MADS_OP_SUB,
        mads_pkg::MADS_OP_SUBC: arith = 1'b1;
        mads_pkg::MADS_OP_INC, mads_pkg::MADS_OP_DEC: begin
          arith = 1'b1;
        end
        mads_pkg::MADS_OP_CLR: begin
          mwe0 = 1'b1;
          mwd0 = 8'h00;
        end
        mads_pkg::MADS_OP_SHR: begin
          shift = 1'b1;
          shres = {1'b0, shsrc[7:1]};
          shco  = shsrc[0];
        end
        mads_pkg::MADS_OP_SHL: begin
          shift = 1'b1;
          shres = {shsrc[6:0], 1'b0};
          shco  = shsrc[7];
        end
        mads_pkg::MADS_OP_RRC: begin
          shift = 1'b1;
          shres = {flag_q[`MADS_F_C], shsrc[7:1]};
          shco  = shsrc[0];
        end
        mads_pkg::MADS_OP_RLC: begin
          shift = 1'b1;
          shres = {shsrc[6:0], flag_q[`MADS_F_C]};
          shco  = shsrc[7];
        end
        mads_pkg::MADS_OP_SWAP: begin
          acc_d = {acc_q[3:0], acc_q[7:4]};
        end
        mads_pkg::MADS_OP_BCLR, mads_pkg::MADS_OP_BSET: begin
          // bit operands outside the low range are refused
          if (ad > `MADS_BIT_MAX) begin
            err_set = 1'b1;
          end else begin
            mwe0       = 1'b1;
            mwd0       = mem_rd;
            mwd0[bsel] = (op_w == mads_pkg::MADS_OP_BSET);
          end
        end
        default: begin
        end
      endcase
      if (arith) begin
        flag_d[`MADS_F_Z]  = (ar[7:0] == 8'h00);
        flag_d[`MADS_F_C]  = ar[8];
        flag_d[`MADS_F_AC] = ar[9];
        flag_d[`MADS_F_OV] = ar[10];
        if (to_mem || op_w == mads_pkg::MADS_OP_INC ||
            op_w == mads_pkg::MADS_OP_DEC) begin
          mwe0 = 1'b1;
          mwd0 = ar[7:0];
        end else begin
          acc_d = ar[7:0];
        end
      end
      if (shift) begin
        flag_d[`MADS_F_C] = shco;
        if (to_mem) begin
          mwe0 = 1'b1;
          mwd0 = shres;
        end else begin
          acc_d = shres;
        end
      end
    end else if (state_q == mads_pkg::MADS_ST_PTR) begin
      mwa0 = ptr_q;
      if (ind_op_q == mads_pkg::MADS_OP_IDXR)
        acc_d = mem_q[ptr_q[MAW-1:0]];
      else
        mwe0 = 1'b1;
    end
    // software access to registers and the memory window
    if (wr && pstrb[0]) begin
      if (paddr == `MADS_REG_ACC)  acc_d  = pwdata[7:0];
      if (paddr == `MADS_REG_FLAG) flag_d = pwdata[3:0];
      if (paddr == `MADS_REG_SP)   sp_d   = pwdata[7:0];
      if (paddr == `MADS_REG_WDATA) begin
        mwa1 = waddr_q;
        mwd1 = pwdata[7:0];
        ioa  = waddr_q;
        iod  = pwdata[7:0];
        mwe1 = ~win_io_q;
        iowe = win_io_q;
      end
    end
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q  <= `MADS_RST_ACC;
      flag_q <= `MADS_RST_FLAG;
      sp_q   <= `MADS_RST_SP;
    end else begin
      acc_q  <= acc_d;
      flag_q <= flag_d;
      sp_q   <= sp_d;
    end
  end

  always_ff @(posedge pclk) begin
    if (mwe0) mem_q[mwa0[MAW-1:0]] <= mwd0;
    if (mwe1) mem_q[mwa1[MAW-1:0]] <= mwd1;
    if (iowe) io_q[ioa[IAW-1:0]]   <= iod;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t16_q <= `MADS_RST_T16;
    end else if (t16_ld) begin
      t16_q <= t16_v;
    end else if (wr && paddr == `MADS_REG_T16) begin
      if (pstrb[0]) t16_q[7:0]  <= pwdata[7:0];
      if (pstrb[1]) t16_q[15:8] <= pwdata[15:8];
    end else if (t16_en_q) begin
      t16_q <= t16_q + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t16_en_q <= 1'b0;
      win_io_q <= 1'b0;
      waddr_q  <= 8'h00;
    end else if (wr && pstrb[0]) begin
      if (paddr == `MADS_REG_CTRL) begin
        t16_en_q <= pwdata[`MADS_CTRL_TEN];
        win_io_q <= pwdata[`MADS_CTRL_WIO];
      end
      if (paddr == `MADS_REG_WADDR) waddr_q <= pwdata[7:0];
    end
  end

  // sticky refusal flag; a new refusal beats a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      err_q <= 1'b0;
    else if (err_set)
      err_q <= 1'b1;
    else if (wr && paddr == `MADS_REG_STAT && pwdata[`MADS_STAT_ERR])
      err_q <= 1'b0;
  end

  // indirect moves: pointer fetch, then data access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q  <= mads_pkg::MADS_ST_IDLE;
      ptr_q    <= 8'h00;
      ind_op_q <= mads_pkg::MADS_OP_NOP;
    end else begin
      unique case (state_q)
        mads_pkg::MADS_ST_IDLE: begin
          if (go && (op_w == mads_pkg::MADS_OP_IDXR ||
                     op_w == mads_pkg::MADS_OP_IDXW)) begin
            state_q  <= mads_pkg::MADS_ST_PTR;
            ptr_q    <= mem_rd;
            ind_op_q <= op_w;
          end
        end
        mads_pkg::MADS_ST_PTR: state_q <= mads_pkg::MADS_ST_IDLE;
      endcase
    end
  end

  // read data sampled every selected cycle, stands at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel) begin
      case (paddr)
        `MADS_REG_ACC:   prdata <= {24'h000000, acc_q};
        `MADS_REG_FLAG:  prdata <= {28'h0000000, flag_q};
        `MADS_REG_SP:    prdata <= {24'h000000, sp_q};
        `MADS_REG_T16:   prdata <= {16'h0000, t16_q};
        `MADS_REG_CTRL:  prdata <= {30'h0, win_io_q, t16_en_q};
        `MADS_REG_WADDR: prdata <= {24'h000000, waddr_q};
        `MADS_REG_WDATA: prdata <= {24'h000000, win_io_q ?
                            io_q[waddr_q[IAW-1:0]] :
                            mem_q[waddr_q[MAW-1:0]]};
        `MADS_REG_STAT:  prdata <= {30'h0, err_q, ~pready};
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic is_add_ai;
  assign is_add_ai = go && op_w == mads_pkg::MADS_OP_ADD &&
                     use_imm && !to_mem;

  zero_flag_a: assert property (go && arith |=>
    flag_q[`MADS_F_Z] == ($past(ar[7:0]) == 8'h00))
    else $error("zero flag wrong after arithmetic");

  add_carry_a: assert property (is_add_ai |=>
    flag_q[`MADS_F_C] ==
      (({1'b0, $past(acc_q)} + {1'b0, $past(imm)}) > 9'h0FF))
    else $error("carry wrong after add");

  half_carry_a: assert property (is_add_ai |=>
    flag_q[`MADS_F_AC] ==
      (({1'b0, $past(acc_q[3:0])} + {1'b0, $past(imm[3:0])}) > 5'h0F))
    else $error("half carry wrong after add");

  bit_range_a: assert property (go &&
    op_w == mads_pkg::MADS_OP_BSET && ad > `MADS_BIT_MAX |=> err_q)
    else $error("high bit operand not refused");

  store_flags_a: assert property (go &&
    op_w == mads_pkg::MADS_OP_STM |=> $stable(flag_q))
    else $error("store changed flags");

  load_zero_a: assert property (go &&
    op_w == mads_pkg::MADS_OP_LDA && !use_imm |=>
    flag_q[`MADS_F_Z] == (acc_q == 8'h00) &&
    flag_q[3:1] == $past(flag_q[3:1]))
    else $error("memory load flags wrong");

  push_step_a: assert property (go &&
    op_w == mads_pkg::MADS_OP_PUSH && !pwdata[`MADS_CMD_MEM] |=>
    sp_q == $past(sp_q) + `MADS_SP_STEP && $stable(flag_q))
    else $error("save did not advance stack by two");

  pop_step_a: assert property (go &&
    op_w == mads_pkg::MADS_OP_POP |=>
    sp_q == $past(sp_q) - `MADS_SP_STEP)
    else $error("restore did not drop stack by two");

  xch_swap_a: assert property (go &&
    op_w == mads_pkg::MADS_OP_XCH |=> acc_q == $past(mem_rd) &&
    mem_q[$past(ad[MAW-1:0])] == $past(acc_q))
    else $error("exchange lost a value");

  sequence ind_start;
    go && op_w == mads_pkg::MADS_OP_IDXR;
  endsequence
  sequence ind_steps;
    state_q == mads_pkg::MADS_ST_PTR && !pready
      ##1 state_q == mads_pkg::MADS_ST_IDLE && pready;
  endsequence
  ind_two_a: assert property (ind_start |=> ind_steps)
    else $error("indirect move not two cycles");

  shift_right_a: assert property (go &&
    op_w == mads_pkg::MADS_OP_SHR && !to_mem |=> !acc_q[7] &&
    flag_q[`MADS_F_C] == $past(acc_q[0]) &&
    flag_q[`MADS_F_Z] == $past(flag_q[`MADS_F_Z]))
    else $error("logical right shift wrong");

  swap_nib_a: assert property (go &&
    op_w == mads_pkg::MADS_OP_SWAP |=>
    acc_q == {$past(acc_q[3:0]), $past(acc_q[7:4])} &&
    $stable(flag_q))
    else $error("nibble swap wrong");

endmodule

// ### verification/mads_apb_master.sv
/*
  APB master in place of program execution: issues register transfers
  to the datapath core, one at a time, one idle cycle between them.
  Assumes pclk from the bench; each call starts just after a rising edge.
*/
`timescale 1ns/1ps
module mads_apb_master (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb,
  // apb answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // --------------------------------------------------------------------
  // bus transfer
  // --------------------------------------------------------------------
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    pstrb   = 4'hF;
  end

  // request held until the edge that samples pready high
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // idle edge: next call never re-drives psel in this time step
    @(posedge pclk);
  endtask
endmodule

// ### verification/mcu_data_arith_shift_datapath_tb_top.sv
/*
  Self-checking bench of the datapath core: commands through APB,
  results read back from registers and the memory window.
  Assumes the core's register map and command word layout.
*/
`timescale 1ns/1ps
`include "mads_params.svh"
module mcu_data_arith_shift_datapath_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic        last_err;
  int          failures, samples_checked, cyc;
  typedef struct packed {
    logic [4:0] op; logic [2:0] fl; logic [7:0] a; logic [3:0] f;
    logic [7:0] m;  logic [7:0] i;  logic [7:0] ea; logic [4:0] ef;
  } mads_vec_t;
  mads_vec_t v;
  // op, {conly,imm,mem}, acc, flags, mem, imm, result, flags (bit4 skip)
  localparam mads_vec_t VEC [22] = '{
    '{5'h0C,3'h2,8'h7F,4'h0,8'h00,8'h01,8'h80,5'h0C},
    '{5'h0C,3'h2,8'hFF,4'h0,8'h00,8'h01,8'h00,5'h07},
    '{5'h0C,3'h1,8'h10,4'h0,8'h20,8'h00,8'h30,5'h00},
    '{5'h0F,3'h2,8'h00,4'h0,8'h00,8'h01,8'hFF,5'h06},
    '{5'h0F,3'h1,8'h01,4'h0,8'h80,8'h00,8'h7F,5'h0C},
    '{5'h0D,3'h4,8'h0F,4'h2,8'h00,8'h00,8'h10,5'h04},
    '{5'h0D,3'h0,8'h01,4'h2,8'hFE,8'h00,8'h00,5'h07},
    '{5'h10,3'h4,8'h80,4'h2,8'h00,8'h00,8'h7F,5'h0C},
    '{5'h10,3'h0,8'h10,4'h2,8'h01,8'h00,8'h0E,5'h04},
    '{5'h0E,3'h0,8'h01,4'h0,8'h03,8'h00,8'h02,5'h00},
    '{5'h11,3'h1,8'h00,4'h0,8'hFF,8'h00,8'h00,5'h07},
    '{5'h12,3'h1,8'h00,4'h0,8'h00,8'h00,8'hFF,5'h06},
    '{5'h13,3'h1,8'h55,4'hF,8'h3C,8'h00,8'h00,5'h0F},
    '{5'h14,3'h0,8'h81,4'h8,8'h00,8'h00,8'h40,5'h0A},
    '{5'h16,3'h0,8'h81,4'h1,8'h00,8'h00,8'h02,5'h03},
    '{5'h15,3'h0,8'h02,4'h2,8'h00,8'h00,8'h81,5'h00},
    '{5'h17,3'h0,8'h80,4'h2,8'h00,8'h00,8'h01,5'h02},
    '{5'h14,3'h1,8'h00,4'h0,8'h01,8'h00,8'h00,5'h02},
    '{5'h18,3'h0,8'h3C,4'hF,8'h00,8'h00,8'hC3,5'h0F},
    '{5'h01,3'h2,8'h55,4'hF,8'h00,8'h00,8'h00,5'h0F},
    '{5'h01,3'h0,8'h55,4'h6,8'h00,8'h00,8'h00,5'h07},
    '{5'h02,3'h1,8'h5A,4'hF,8'h00,8'h00,8'h5A,5'h0F}};

  mads_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  mads_apb_master bus (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    bus.xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    bus.xfer(1'b0, a, 32'h0, r, e);
    last_err = e;
    chk(r, x);
  endtask
  task automatic rda(input logic [7:0] x);
    rd(`MADS_REG_ACC, {24'h0, x});
  endtask
  task automatic rdf(input logic [3:0] x);
    rd(`MADS_REG_FLAG, {28'h0, x});
  endtask
  task automatic mw(input logic [7:0] a, input logic [7:0] d);
    wr(`MADS_REG_WADDR, {24'h0, a});
    wr(`MADS_REG_WDATA, {24'h0, d});
  endtask
  task automatic mr(input logic [7:0] a, input logic [7:0] x);
    wr(`MADS_REG_WADDR, {24'h0, a});
    rd(`MADS_REG_WDATA, {24'h0, x});
  endtask
  task automatic cmd(input logic [4:0] op, input logic [2:0] fl,
                     input logic [7:0] m, input logic [7:0] i = 8'h00,
                     input logic [2:0] b = 3'h0);
    wr(`MADS_REG_CMD, {5'h0, b, i, m, fl, op});
  endtask
  task automatic wrap_up;
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // --------------------------------------------------------------------
  // clock, reset, timeout
  // --------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
  end

  // --------------------------------------------------------------------
  // tests
  // --------------------------------------------------------------------
  initial begin
    failures = 0;
    samples_checked = 0;
    cyc = 0;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rda(8'h00);
    rdf(4'h0);
    rd(`MADS_REG_SP, 32'h0);
    rd(`MADS_REG_T16, 32'h0);
    rd(8'h24, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    foreach (VEC[k]) begin
      v = VEC[k];
      wr(`MADS_REG_ACC, {24'h0, v.a});
      wr(`MADS_REG_FLAG, {28'h0, v.f});
      mw(8'h33, v.m);
      cmd(v.op, v.fl, 8'h33, v.i);
      if (v.fl[0]) mr(8'h33, v.ea);
      else rda(v.ea);
      if (!v.ef[4]) rdf(v.ef[3:0]);
      if (v.fl[0]) rda(v.a);
      else mr(8'h33, v.m);
    end
    wr(`MADS_REG_FLAG, 32'h5);
    wr(`MADS_REG_T16, 32'h1234);
    cmd(5'h05, 3'h0, 8'h30);
    mr(8'h30, 8'h34);
    mr(8'h31, 8'h12);
    mw(8'h40, 8'hCD);
    mw(8'h41, 8'hAB);
    cmd(5'h06, 3'h0, 8'h40);
    rd(`MADS_REG_T16, 32'hABCD);
    rdf(4'h5);
    mw(8'h50, 8'h60);
    mw(8'h60, 8'hA5);
    cmd(5'h07, 3'h0, 8'h50);
    rda(8'hA5);
    wr(`MADS_REG_ACC, 32'h3C);
    cmd(5'h08, 3'h0, 8'h50);
    mr(8'h60, 8'h3C);
    mw(8'h70, 8'h22);
    wr(`MADS_REG_ACC, 32'h11);
    cmd(5'h09, 3'h0, 8'h70);
    rda(8'h22);
    mr(8'h70, 8'h11);
    rdf(4'h5);
    wr(`MADS_REG_SP, 32'h10);
    wr(`MADS_REG_ACC, 32'h99);
    cmd(5'h0A, 3'h0, 8'h00);
    rd(`MADS_REG_SP, 32'h12);
    mr(8'h10, 8'h99);
    mr(8'h11, 8'h05);
    wr(`MADS_REG_ACC, 32'h0);
    wr(`MADS_REG_FLAG, 32'hA);
    cmd(5'h0B, 3'h0, 8'h00);
    rd(`MADS_REG_SP, 32'h10);
    rda(8'h99);
    rdf(4'h5);
    cmd(5'h1A, 3'h0, 8'h80);
    rd(`MADS_REG_STAT, 32'h2);
    wr(`MADS_REG_STAT, 32'h2);
    mw(8'h7F, 8'hFF);
    cmd(5'h19, 3'h0, 8'h7F, 8'h00, 3'h3);
    mr(8'h7F, 8'hF7);
    rd(`MADS_REG_STAT, 32'h0);
    wr(`MADS_REG_ACC, 32'h5A);
    cmd(5'h04, 3'h0, 8'h05);
    wr(`MADS_REG_ACC, 32'h0);
    wr(`MADS_REG_FLAG, 32'h1);
    cmd(5'h03, 3'h0, 8'h05);
    rda(8'h5A);
    rdf(4'h0);
    wr(`MADS_REG_CTRL, 32'h2);
    mr(8'h05, 8'h5A);
    wrap_up();
  end
endmodule
